// ---- src/i2cesc_pkg.sv ----
/*
 * constants shared by the error-status / bit-rate block of the two-wire
 * interface: register indices, field positions, reset values, gen states.
 * assumes a 32-bit apb bus; each register index is one aligned word.
 */
package i2cesc_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h18; // interface control
    localparam logic [7:0] IDX_ST2 = 8'h1a; // status_two
    localparam logic [7:0] IDX_CCR = 8'h1b; // bit_rate_control
    localparam logic [7:0] IDX_MASK = 8'h1f; // interrupt mask
    localparam int ADDR_W = 12; // apb address width

    // control fields
    localparam int CR_PE = 5; // interface_on
    localparam int CR_GENERAL_CALL_ENABLE = 4; // general_call_enable
    localparam int CR_ACK = 2; // ack_enable
    localparam int CR_ITE = 0; // interrupt_enable
    localparam logic [7:0] CTRL_WMASK = 8'h35; // writable control bits

    // status_two fields
    localparam int ST_AF = 4; // no_acknowledge_flag
    localparam int ST_STOP_SEEN_FLAG = 3; // stop_seen_flag
    localparam int ST_ARBITRATION_LOST_FLAG = 2; // arbitration_lost_flag
    localparam int ST_BUS_ERROR_FLAG = 1; // bus_error_flag
    localparam int ST_GENERAL_CALL_FLAG = 0; // general_call_flag
    localparam logic [7:0] ST2_USED = 8'h1f; // upper three read zero
    localparam logic [7:0] ST2_RDCLR = 8'h1e; // flags a read clears

    // bit_rate_control fields
    localparam int CCR_FM = 7; // fast_mode_select
    localparam int DIV_W = 7; // scl_divider width

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ST2_RST = 8'h00;
    localparam logic [7:0] CCR_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h1f;

    // scl half-period units in pclk cycles per divider step
    localparam int STD_UNIT = 10;
    localparam int FAST_UNIT = 4;

    // scl generator states, gray along idle -> low -> high
    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00,
        GEN_LOW = 2'b01,
        GEN_HIGH = 2'b11
    } i2cesc_gen_type;

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : reg_addr

endpackage : i2cesc_pkg

// ---- src/i2cesc_scl_if.sv ----
/*
 * carrier between the register logic and the scl rate generator.
 * assumes both ends sit on pclk.
 */
`timescale 1ns/10ps
interface i2cesc_scl_if;
    import i2cesc_pkg::*;
    logic enable; // interface_on
    logic fast; // fast_mode_select
    logic [DIV_W-1:0] divider; // scl_divider
    logic level; // generated scl level
    logic tick; // one-cycle pulse at each scl edge but the rise when enable drops
    modport ctl (output enable, output fast, output divider,
                 input level, input tick);
    modport gen (input enable, input fast, input divider,
                 output level, output tick);
endinterface : i2cesc_scl_if

// ---- src/i2cesc_sclgen.sv ----
/*
 * scl rate generator: half period = (divider + 1) * unit pclk cycles,
 * unit chosen by the speed mode. assumes pclk at 125 mhz.
 */
`timescale 1ns/10ps
module i2cesc_sclgen
    import i2cesc_pkg::*;
#(
    parameter int STD_CYC = STD_UNIT,
    parameter int FAST_CYC = FAST_UNIT,
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    i2cesc_scl_if.gen sif
);
    // refuse units the counter cannot hold
    if (STD_CYC < 1 || FAST_CYC < 1 ||
        (128 * STD_CYC) >= (1 << CNT_W) ||
        (128 * FAST_CYC) >= (1 << CNT_W)) begin : g_chk
        $error("scl unit out of range");
    end

    typedef struct packed {
        i2cesc_gen_type st; // phase
        logic [CNT_W-1:0] cnt; // cycles left in phase
        logic level; // scl level
        logic tick; // edge pulse
    } i2cesc_gen_state_type;

    i2cesc_gen_state_type s_r, s_nxt;
    logic [CNT_W-1:0] half; // half period, cycles

    ////////////////////////////////////////////////////////////////////
    // half period from divider and mode, read each phase start
    always_comb begin
        half = CNT_W'((32'(sif.divider) + 32'd1) *
                      (sif.fast ? FAST_CYC : STD_CYC));
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        case (s_r.st)
            GEN_IDLE: begin // parked high
                s_nxt.level = 1'b1;
                if (sif.enable) begin
                    s_nxt.st = GEN_LOW;
                    s_nxt.cnt = half;
                    s_nxt.level = 1'b0;
                    s_nxt.tick = 1'b1;
                end
            end
            GEN_LOW, GEN_HIGH: begin
                if (!sif.enable) begin // stop at once
                    s_nxt.st = GEN_IDLE;
                    s_nxt.level = 1'b1;
                end else if (s_r.cnt <= CNT_W'(1)) begin
                    s_nxt.st = (s_r.st == GEN_LOW) ? GEN_HIGH : GEN_LOW;
                    s_nxt.cnt = half;
                    s_nxt.level = (s_r.st == GEN_LOW);
                    s_nxt.tick = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - CNT_W'(1);
                end
            end
            default: s_nxt.st = GEN_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: GEN_IDLE, cnt: '0, level: 1'b1, tick: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.level = s_r.level;
    assign sif.tick = s_r.tick;

endmodule : i2cesc_sclgen

// ---- src/i2cesc_top.sv ----
/*
 * status_two and bit_rate_control of the two-wire interface, plus the
 * control and mask registers, behind an apb slave; one level irq.
 * assumes event inputs are one-cycle pulses from bit logic on pclk.
 */
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module i2cesc_top
    import i2cesc_pkg::*;
#(
    parameter int STD_CYC = STD_UNIT,
    parameter int FAST_CYC = FAST_UNIT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nack_evt, // no ack after a sent byte
    input wire logic stop_evt, // stop condition seen
    input wire logic arb_lost_evt, // another master won
    input wire logic rx_ack_slot, // master-receive ack bit in progress
    input wire logic misplaced_evt, // misplaced start or stop
    input wire logic gcall_addr_evt, // general call address received
    input wire logic start_req, // start written, enter master role
    input wire logic start_sent_flag,
    input wire logic byte_done_flag,
    output logic irq,
    output logic scl_hold, // scl stretch request
    output logic master_role_flag,
    output logic interface_on,
    output logic general_call_enable,
    output logic ack_enable,
    output logic interrupt_enable,
    output logic scl_level,
    output logic scl_tick
);

    typedef struct packed {
        logic [7:0] ctrl; // control
        logic [7:0] st2; // status_two
        logic [7:0] bit_rate_control; // bit_rate_control
        logic [7:0] mask; // interrupt mask
        logic master; // master_role_flag
        logic [7:0] cap; // status_two value handed to the reader
        logic rd_st2; // current access reads status_two
        logic [7:0] rdata; // read data
        logic ready; // access phase answer
        logic err; // unmapped address
        logic irq; // interrupt line
        logic hold; // scl stretch
    } i2cesc_top_state_type;

    i2cesc_top_state_type s_r, s_nxt;
    i2cesc_scl_if sif ();

    logic setup; // apb setup cycle
    logic done; // apb access completes at this edge
    logic pe; // interface_on
    logic slave; // not master
    logic [7:0] set_v; // flags set this cycle
    logic [7:0] clr_v; // flags cleared this cycle

    ////////////////////////////////////////////////////////////////////
    // register decode, used for hit and read mux
    function automatic logic [7:0] rd_mux(
        input logic [ADDR_W-1:0] a, input i2cesc_top_state_type s);
        logic [7:0] v;
        v = 8'h00;
        if (a == reg_addr(IDX_CTRL)) v = s.ctrl;
        if (a == reg_addr(IDX_ST2)) v = s.st2 & ST2_USED;
        if (a == reg_addr(IDX_CCR)) v = s.bit_rate_control;
        if (a == reg_addr(IDX_MASK)) v = s.mask;
        return v;
    endfunction : rd_mux

    function automatic logic hit(input logic [ADDR_W-1:0] a);
        return a == reg_addr(IDX_CTRL) || a == reg_addr(IDX_ST2) ||
               a == reg_addr(IDX_CCR) || a == reg_addr(IDX_MASK);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // event qualification
    always_comb begin
        setup = psel && !penable;
        done = psel && penable && s_r.ready;
        pe = s_r.ctrl[CR_PE];
        slave = !s_r.master;
        set_v = 8'h00;
        set_v[ST_AF] = nack_evt;
        set_v[ST_STOP_SEEN_FLAG] = stop_evt && slave && s_r.ctrl[CR_ACK];
        // ack slot of a master receive is not arbitrated
        set_v[ST_ARBITRATION_LOST_FLAG] = arb_lost_evt && s_r.master && !rx_ack_slot;
        set_v[ST_BUS_ERROR_FLAG] = misplaced_evt;
        set_v[ST_GENERAL_CALL_FLAG] = gcall_addr_evt && slave &&
                         s_r.ctrl[CR_GENERAL_CALL_ENABLE];
        // clear only what the reader saw, so a flag set meanwhile stays
        clr_v = (done && s_r.rd_st2) ? (s_r.cap & ST2_RDCLR) : 8'h00;
        clr_v[ST_GENERAL_CALL_FLAG] = set_v[ST_STOP_SEEN_FLAG];
    end

    ////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        s_nxt = s_r;
        // apb slave, one access cycle, answer always registered
        s_nxt.ready = 1'b0;
        s_nxt.err = 1'b0; // error answer stands with pready only
        if (setup) begin
            s_nxt.ready = 1'b1;
            s_nxt.err = !hit(paddr);
            s_nxt.rdata = pwrite ? 8'h00 : rd_mux(paddr, s_r);
            s_nxt.rd_st2 = !pwrite && paddr == reg_addr(IDX_ST2);
            s_nxt.cap = s_r.st2;
        end else if (done) begin
            s_nxt.err = 1'b0;
            s_nxt.rd_st2 = 1'b0;
        end
        if (done && pwrite && !s_r.err) begin
            if (paddr == reg_addr(IDX_CTRL)) begin
                s_nxt.ctrl = pwdata[7:0] & CTRL_WMASK;
            end
            if (paddr == reg_addr(IDX_CCR)) begin
                s_nxt.bit_rate_control = pwdata[7:0];
            end
            if (paddr == reg_addr(IDX_MASK)) begin
                s_nxt.mask = pwdata[7:0] & ST2_USED;
            end
            // status_two writes are ignored
        end
        // flags: set wins over clear; interface off clears all
        if (pe) begin
            s_nxt.st2 = ((s_r.st2 & ~clr_v) | set_v) & ST2_USED;
        end else begin
            s_nxt.st2 = ST2_RST;
        end
        // bit_rate_control is untouched by interface off
        // master role
        if (!pe) begin
            s_nxt.master = 1'b0;
        end else if (set_v[ST_ARBITRATION_LOST_FLAG] || stop_evt) begin
            s_nxt.master = 1'b0;
        end else if (start_req) begin
            s_nxt.master = 1'b1;
        end
        // level irq, gated by interrupt_enable
        s_nxt.irq = s_nxt.ctrl[CR_ITE] &&
                    |(s_nxt.st2 & s_nxt.mask);
        // only start-sent and byte-done stretch scl
        s_nxt.hold = start_sent_flag || byte_done_flag;
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{ctrl: CTRL_RST, st2: ST2_RST, bit_rate_control: CCR_RST,
                     mask: MASK_RST, master: 1'b0, cap: 8'h00,
                     rd_st2: 1'b0, rdata: 8'h00, ready: 1'b0,
                     err: 1'b0, irq: 1'b0, hold: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // scl rate generator
    assign sif.enable = pe;
    assign sif.fast = s_r.bit_rate_control[CCR_FM];
    assign sif.divider = s_r.bit_rate_control[DIV_W-1:0];

    i2cesc_sclgen #(
        .STD_CYC(STD_CYC),
        .FAST_CYC(FAST_CYC),
        .CNT_W(16)
    ) u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign prdata = {24'h000000, s_r.rdata};
    assign pready = s_r.ready;
    assign pslverr = s_r.err;
    assign irq = s_r.irq;
    assign scl_hold = s_r.hold;
    assign master_role_flag = s_r.master;
    assign interface_on = s_r.ctrl[CR_PE];
    assign general_call_enable = s_r.ctrl[CR_GENERAL_CALL_ENABLE];
    assign ack_enable = s_r.ctrl[CR_ACK];
    assign interrupt_enable = s_r.ctrl[CR_ITE];
    assign scl_level = sif.level;
    assign scl_tick = sif.tick;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rsvd_zero_a: assert property (
        pready && s_r.rd_st2 |-> prdata[7:5] == 3'b000)
        else $error("reserved status bits not zero");

    af_set_a: assert property (
        interface_on && nack_evt |=> s_r.st2[ST_AF] ##1
        (irq || !interrupt_enable || !s_r.mask[ST_AF]))
        else $error("ack failure not flagged");

    rd_clear_a: assert property (
        done && s_r.rd_st2 && s_r.cap[ST_BUS_ERROR_FLAG] && !misplaced_evt
        |=> !s_r.st2[ST_BUS_ERROR_FLAG])
        else $error("bus error not cleared by read");

    off_clear_a: assert property (
        !interface_on |=> s_r.st2 == 8'h00)
        else $error("flags survive interface off");

    no_stretch_a: assert property (
        scl_hold == $past(start_sent_flag || byte_done_flag))
        else $error("scl stretched by an error flag");

    stop_set_a: assert property (
        interface_on && stop_evt && !master_role_flag && ack_enable
        |=> s_r.st2[ST_STOP_SEEN_FLAG] && !s_r.st2[ST_GENERAL_CALL_FLAG])
        else $error("stop not flagged or call kept");

    arbitration_lost_flag_role_a: assert property (
        interface_on && arb_lost_evt && master_role_flag && !rx_ack_slot
        |=> s_r.st2[ST_ARBITRATION_LOST_FLAG] && !master_role_flag)
        else $error("arbitration loss kept master role");

    arbitration_lost_flag_skip_a: assert property (
        arb_lost_evt && rx_ack_slot && !s_r.st2[ST_ARBITRATION_LOST_FLAG] && interface_on
        && !(done && s_r.rd_st2) |=> !s_r.st2[ST_ARBITRATION_LOST_FLAG])
        else $error("arbitration flagged in ack slot");

    bus_error_flag_set_a: assert property (
        interface_on && misplaced_evt |=> s_r.st2[ST_BUS_ERROR_FLAG])
        else $error("bus error not flagged");

    general_call_flag_hold_a: assert property (
        s_r.st2[ST_GENERAL_CALL_FLAG] && interface_on && !stop_evt
        |=> s_r.st2[ST_GENERAL_CALL_FLAG])
        else $error("general call flag lost early");

    ccr_keep_a: assert property (
        !(done && pwrite) |=> $stable(s_r.bit_rate_control))
        else $error("bit rate changed without write");

    irq_gate_a: assert property (
        irq |-> interrupt_enable && |(s_r.st2 & s_r.mask))
        else $error("irq without enabled flag");

    rd_clear_af_a: assert property (
        done && s_r.rd_st2 && s_r.cap[ST_AF] && !nack_evt
        |=> !s_r.st2[ST_AF])
        else $error("ack failure not cleared by read");

    stop_master_a: assert property (
        interface_on && stop_evt && master_role_flag && !s_r.st2[ST_STOP_SEEN_FLAG]
        |=> !s_r.st2[ST_STOP_SEEN_FLAG])
        else $error("stop flagged in master role");

    off_role_a: assert property (
        !interface_on |=> !master_role_flag)
        else $error("master role kept with interface off");

    ccr_write_a: assert property (
        done && pwrite && paddr == reg_addr(IDX_CCR)
        |=> s_r.bit_rate_control == $past(pwdata[7:0]))
        else $error("bit rate write lost");

    scl_park_a: assert property (
        !interface_on |=> scl_level)
        else $error("scl not parked high when off");

    general_call_flag_set_a: assert property (
        interface_on && gcall_addr_evt && !master_role_flag &&
        general_call_enable |=> s_r.st2[ST_GENERAL_CALL_FLAG])
        else $error("general call not flagged");

    arbitration_lost_flag_irq_a: assert property (
        interface_on && interrupt_enable && s_r.mask[ST_ARBITRATION_LOST_FLAG] &&
        arb_lost_evt && master_role_flag && !rx_ack_slot &&
        !(done && pwrite) |=> irq)
        else $error("arbitration loss raised no irq");

endmodule : i2cesc_top

// ---- tb/i2c_error_status_and_clock_divider_test.sv ----
/*
 * self-checking bench: apb tasks, event scenarios, scl rate checks.
 * assumes i2cesc_bus_model as far side and a 125 mhz pclk.
 */
`timescale 1ns/10ps
module i2c_error_status_and_clock_divider_test;
    import i2cesc_pkg::*;
    localparam int STD_T = 2; // shortened std unit, keeps runs short
    localparam int FAST_T = 1; // shortened fast unit
    localparam int LIMIT = 20000; // cycle ceiling, tests need ~200
    logic pclk, presetn, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq, scl_hold, master_role_flag;
    logic interface_on, scl_tick, rx_ack_slot, err;
    logic general_call_enable, ack_enable, interrupt_enable, scl_level;
    logic [5:0] evt;
    logic [1:0] hold_src;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int gap;
    int ev_id[3] = '{0, 3, 1}; // nack, misplaced+stop, stop
    logic [31:0] ev_exp[3] = '{32'h10, 32'h0a, 32'h08};

    i2cesc_bus_model i_i2cesc_bus_model (.pclk(pclk), .evt(evt),
        .rx_ack_slot(rx_ack_slot), .hold_src(hold_src));
    i2cesc_top #(.STD_CYC(STD_T), .FAST_CYC(FAST_T)) i_i2cesc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nack_evt(evt[0]), .stop_evt(evt[1]), .arb_lost_evt(evt[2]),
        .rx_ack_slot(rx_ack_slot), .misplaced_evt(evt[3]),
        .gcall_addr_evt(evt[4]), .start_req(evt[5]),
        .start_sent_flag(hold_src[1]), .byte_done_flag(hold_src[0]),
        .irq(irq), .scl_hold(scl_hold),
        .master_role_flag(master_role_flag),
        .interface_on(interface_on),
        .general_call_enable(general_call_enable),
        .ack_enable(ack_enable), .interrupt_enable(interrupt_enable),
        .scl_level(scl_level), .scl_tick(scl_tick));

    ////////////////////////////////////////
    // 8 ns clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // hang guard: counts as a mismatch
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : check

    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : chk1

    // one apb transfer; held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // registered outputs settle before any level check
        @(negedge pclk);
    endtask : apb

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask : rdchk

    // event pulse, then one edge so flag and irq updates land
    task automatic ev(input int n);
        i_i2cesc_bus_model.pulse(n);
        @(posedge pclk);
    endtask : ev

    // cycles between two scl edge ticks
    task automatic half_period(output int n);
        @(posedge pclk);
        while (scl_tick !== 1'b1) begin
            @(posedge pclk);
        end
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (scl_tick !== 1'b1);
    endtask : half_period

    ////////////////////////////////////////
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(IDX_CTRL, 32'h0);
        rdchk(IDX_CCR, 32'h0);
        rdchk(IDX_MASK, 32'h1f);
        chk1(scl_level, 1'b1);
        apb(1'b1, IDX_ST2, 8'hff);
        rdchk(IDX_ST2, 32'h0);
        apb(1'b0, 8'h20, 8'h00);
        chk1(err, 1'b1);
        $display("test registers done");
        // rate: fast then standard, divider 3
        apb(1'b1, IDX_CCR, 8'h83);
        rdchk(IDX_CCR, 32'h83);
        apb(1'b1, IDX_CTRL, 8'h35);
        chk1(interface_on, 1'b1);
        chk1(general_call_enable, 1'b1);
        chk1(ack_enable, 1'b1);
        chk1(interrupt_enable, 1'b1);
        half_period(gap);
        half_period(gap);
        check(gap, 4 * FAST_T);
        apb(1'b1, IDX_CCR, 8'h03);
        half_period(gap);
        half_period(gap);
        check(gap, 4 * STD_T);
        apb(1'b1, IDX_CTRL, 8'h00);
        chk1(general_call_enable, 1'b0);
        rdchk(IDX_CCR, 32'h03);
        chk1(scl_level, 1'b1);
        $display("test rate done");
        // flag events with irq and read-clear
        apb(1'b1, IDX_CTRL, 8'h35);
        foreach (ev_id[i]) begin
            ev(ev_id[i]);
            chk1(irq, 1'b1);
            chk1(scl_hold, 1'b0);
            rdchk(IDX_ST2, ev_exp[i]);
            rdchk(IDX_ST2, 32'h0);
            chk1(irq, 1'b0);
        end
        ev(5);
        chk1(master_role_flag, 1'b1);
        ev(2);
        chk1(master_role_flag, 1'b0);
        rdchk(IDX_ST2, 32'h04);
        ev(5);
        i_i2cesc_bus_model.set_levels(1'b1, 2'h0);
        ev(2);
        rdchk(IDX_ST2, 32'h0);
        chk1(master_role_flag, 1'b1);
        i_i2cesc_bus_model.set_levels(1'b0, 2'h0);
        ev(1);
        apb(1'b0, IDX_ST2, 8'h00);
        ev(4);
        rdchk(IDX_ST2, 32'h01);
        rdchk(IDX_ST2, 32'h01);
        ev(1);
        rdchk(IDX_ST2, 32'h08);
        // stop with acknowledge disabled leaves the stop flag clear
        apb(1'b1, IDX_CTRL, 8'h31);
        ev(1);
        rdchk(IDX_ST2, 32'h0);
        $display("test events done");
        // interrupt gating: enable bit, then mask
        apb(1'b1, IDX_CTRL, 8'h34);
        chk1(interrupt_enable, 1'b0);
        ev(0);
        chk1(irq, 1'b0);
        rdchk(IDX_ST2, 32'h10);
        apb(1'b1, IDX_CTRL, 8'h35);
        apb(1'b1, IDX_MASK, 8'h00);
        ev(0);
        chk1(irq, 1'b0);
        apb(1'b1, IDX_MASK, 8'h1f);
        repeat (2) @(posedge pclk);
        chk1(irq, 1'b1);
        ev(4);
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b1, IDX_CTRL, 8'h35);
        rdchk(IDX_ST2, 32'h0);
        $display("test irq done");
        // stretch only from start-sent or byte-done
        i_i2cesc_bus_model.set_levels(1'b0, 2'h1);
        repeat (2) @(posedge pclk);
        chk1(scl_hold, 1'b1);
        ev(0);
        @(posedge pclk);
        chk1(scl_hold, 1'b0);
        $display("test stretch done");
        give_verdict();
    end
endmodule : i2c_error_status_and_clock_divider_test

// ---- tb/i2cesc_bus_model.sv ----
/*
 * far-side model: event pulses and level flags that the bit logic
 * and other bus parties present to the status block.
 * assumes pclk from the bench; its tasks are called by the bench.
 */
`timescale 1ns/10ps
module i2cesc_bus_model (
    input wire logic pclk,
    output logic [5:0] evt, // nack,stop,arb,misplaced,gcall,start
    output logic rx_ack_slot, // master-receive ack bit level
    output logic [1:0] hold_src // start_sent, byte_done levels
);
    // quiet bus at time zero
    initial begin
        evt = 6'h00;
        rx_ack_slot = 1'b0;
        hold_src = 2'h0;
    end

    ////////////////////////////////////////
    // one-cycle pulse, launched after an edge
    task automatic pulse(input int n);
        @(posedge pclk);
        evt[n] <= 1'b1;
        @(posedge pclk);
        evt <= 6'h00;
        // no ack: software frees both lines, so no stretch source stays
        if (n == 0) begin
            hold_src <= 2'h0;
        end
        // misplaced start/stop: master resyncs with a stop after one idle cycle
        if (n == 3) begin
            @(posedge pclk);
            evt[1] <= 1'b1;
            @(posedge pclk);
            evt <= 6'h00;
        end
    endtask : pulse

    // level flags change only just after an edge
    task automatic set_levels(input logic slot, input logic [1:0] hs);
        @(posedge pclk);
        rx_ack_slot <= slot;
        hold_src <= hs;
    endtask : set_levels
endmodule : i2cesc_bus_model
